// ---- design/zone_event_pkg.sv ----
// Purpose: shared types and constants for zone set and event selection
// Assumes: values are signed engineering units, 16 bits wide
// Notes:   event type codes keep the numbering of the assignment list
package zone_event_pkg;
  localparam int VAL_W      = 16;
  localparam int N_CH       = 12;  // 3 event + 9 digital outputs
  localparam int N_SETS     = 8;
  localparam int CH_DO1     = 3;
  localparam int CH_DO4     = 6;
  localparam int CH_DO6     = 8;
  localparam int N_DO       = 9;
  localparam logic signed [VAL_W-1:0] BAND_MAX  = 16'sh2710; // 10000
  localparam logic signed [VAL_W-1:0] BAND_INIT = 16'sh0014; // 20
  localparam logic signed [VAL_W-1:0] ZONE_INIT = 16'sh0000;
  localparam logic signed [VAL_W-1:0] DEV_MAX   = 16'sh61A8; // 25000
  localparam logic signed [VAL_W-1:0] DEV_MIN   = -16'sh61A8;
  localparam logic signed [VAL_W-1:0] HYS_INIT  = 16'sh0014; // 20
  localparam logic signed [VAL_W-1:0] HYS_MIN   = 16'sh0001;
  localparam logic signed [VAL_W-1:0] HYS_MAX   = 16'sh270F; // 9999
  localparam logic signed [VAL_W-1:0] POS_HYS_INIT = 16'sh0001; // 0.1%
  localparam logic signed [VAL_W-1:0] POS_HYS_MAX  = 16'sh0032; // 5.0%
  localparam logic signed [VAL_W-1:0] POS_HI_INIT  = 16'sh03E8; // 100.0%
  localparam logic signed [VAL_W-1:0] POS_LO_INIT  = 16'sh0000;
  localparam logic signed [VAL_W-1:0] AT_OFS_INIT  = 16'sh0000;

  typedef enum logic [4:0] {
    TY_NONE = 5'h01, TY_DEVIATION_HIGH_ALARM = 5'h02, TY_DEV_LO = 5'h03,
    TY_DEVIATION_OUTSIDE_BAND = 5'h04, TY_DEVIATION_INSIDE_BAND = 5'h05, TY_MEAS_HI = 5'h06,
    TY_MEAS_LO = 5'h07, TY_SET_HI = 5'h08, TY_SET_LO = 5'h09,
    TY_AUTOTUNE = 5'h0A, TY_HAND = 5'h0B, TY_EXT_SP = 5'h0C,
    TY_SLOPE = 5'h0D, TY_HALTED = 5'h0E, TY_ANY_OVER = 5'h0F,
    TY_MEAS_OVER = 5'h10, TY_EXT_OVER = 5'h11, TY_LOGIC = 5'h12,
    TY_DIRECT = 5'h13, TY_POS_HI = 5'h14, TY_POS_LO = 5'h15,
    TY_POT_FAULT = 5'h16
  } ev_type_t;

  typedef enum logic [1:0] {
    ZONE_OFF = 2'h0, ZONE_BY_SET = 2'h1, ZONE_BY_MEAS = 2'h2
  } zone_mode_t;

  typedef enum logic [1:0] {
    LOG_AND = 2'h0, LOG_OR = 2'h1, LOG_XOR = 2'h2
  } logic_op_t;

  typedef enum logic [2:0] {
    WR_TYPE = 3'h0, WR_EV_SP = 3'h1, WR_EV_HYS = 3'h2, WR_LOGIC = 3'h3,
    WR_ZONE_THR = 3'h4, WR_BAND = 3'h5, WR_ZONE_MODE = 3'h6, WR_AT_OFS = 3'h7
  } wr_sel_t;

  typedef struct packed {
    logic signed [VAL_W-1:0] meas;
    logic signed [VAL_W-1:0] setp;
    logic signed [VAL_W-1:0] pos;
  } proc_vals_t;

  typedef struct packed {
    logic autotune;
    logic hand;
    logic external_sp;
    logic slope;
    logic halted;
    logic meas_over;
    logic ext_over;
    logic pot_fault;
  } status_t;

  typedef struct packed {
    ev_type_t                ty;
    logic signed [VAL_W-1:0] sp;
    logic signed [VAL_W-1:0] hys;
    logic_op_t               op;
  } chan_cfg_t;
endpackage

// ---- design/zone_set_select.sv ----
// Purpose: picks the active parameter set from zones or the setpoint index
// Assumes: thresholds indexed by set number, one common band
// Notes:   switching waits until the reference leaves every band
module zone_set_select
  import zone_event_pkg::*;
#(
  parameter int SETS = N_SETS
) (
  input  wire logic                      i_clk,   // 250 MHz clock
  input  wire logic                      i_rstn,  // async reset, low
  input  wire logic                      i_ce,    // clock enable
  input  wire zone_event_pkg::zone_mode_t i_mode, // zone selector
  input  wire logic signed [VAL_W-1:0]   i_ref,   // reference value
  input  wire logic signed [VAL_W-1:0]   i_band,  // common zone band
  input  wire logic [SETS-1:0][VAL_W-1:0] i_thr,  // zone thresholds
  input  wire logic [$clog2(SETS)-1:0]   i_sp_idx,// selected setpoint no.
  output logic [$clog2(SETS)-1:0]        o_set    // active set
);
  typedef enum logic [1:0] {ZS_TRACK = 2'b01, ZS_HOLD = 2'b10} zs_t;
  localparam int IW = $clog2(SETS);
  zs_t                 state_q;
  logic [IW-1:0]       set_q;
  logic [IW-1:0]       cand;
  logic                near;
  logic signed [VAL_W+1:0] diff;

  // first set whose threshold is not below the reference; ties go low
  always_comb begin
    cand = IW'(SETS - 1);
    near = 1'b0;
    diff = '0;
    for (int i = SETS - 1; i >= 0; i--) begin
      if (i_ref <= $signed(i_thr[i])) cand = IW'(i);
    end
    for (int i = 0; i < SETS; i++) begin
      diff = (VAL_W+2)'(i_ref) - (VAL_W+2)'($signed(i_thr[i]));
      if (diff <= (VAL_W+2)'(i_band) && -diff <= (VAL_W+2)'(i_band))
        near = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ZS_TRACK;
      set_q   <= '0;
    end else if (i_ce) begin
      if (i_mode == ZONE_OFF) begin
        state_q <= ZS_TRACK;
        set_q   <= i_sp_idx;
      end else begin
        case (state_q)
          ZS_TRACK: if (near) state_q <= ZS_HOLD;
                    else set_q <= cand;
          ZS_HOLD:  if (!near) begin
                      state_q <= ZS_TRACK;
                      set_q   <= cand;
                    end
          default:  state_q <= ZS_TRACK;
        endcase
      end
    end
  end
  assign o_set = set_q;
endmodule

// ---- design/event_level.sv ----
// Purpose: next on state of one event channel from its type and inputs
// Assumes: previous state fed back by the caller
// Notes:   purely combinational, one copy per channel
module event_level
  import zone_event_pkg::*;
(
  input  wire zone_event_pkg::chan_cfg_t i_cfg,  // channel setup
  input  wire zone_event_pkg::proc_vals_t i_val, // process values
  input  wire zone_event_pkg::status_t   i_st,   // state flags
  input  wire logic                      i_logic,// gate or timer result
  input  wire logic                      i_direct,// link driven level
  input  wire logic                      i_prev, // current on state
  output logic                           o_on    // next on state
);
  localparam int W = VAL_W + 2;
  logic signed [W-1:0] dev, adev, sp, hys;

  // on at or past the limit, off once back by the hysteresis
  function automatic logic above(logic signed [W-1:0] x, lim, h, logic p);
    return (x >= lim) || (p && x > lim - h);
  endfunction
  function automatic logic below(logic signed [W-1:0] x, lim, h, logic p);
    return (x <= lim) || (p && x < lim + h);
  endfunction

  assign dev  = W'(i_val.meas) - W'(i_val.setp);
  assign adev = dev < 0 ? -dev : dev;
  assign sp   = W'(i_cfg.sp);
  assign hys  = W'(i_cfg.hys);

  always_comb begin
    case (i_cfg.ty)
      TY_DEVIATION_HIGH_ALARM:    o_on = above(dev, sp, hys, i_prev);
      TY_DEV_LO:    o_on = below(dev, sp, hys, i_prev);
      TY_DEVIATION_OUTSIDE_BAND:   o_on = above(adev, sp, hys, i_prev);
      TY_DEVIATION_INSIDE_BAND:    o_on = below(adev, sp, hys, i_prev);
      TY_MEAS_HI:   o_on = above(W'(i_val.meas), sp, hys, i_prev);
      TY_MEAS_LO:   o_on = below(W'(i_val.meas), sp, hys, i_prev);
      TY_SET_HI:    o_on = above(W'(i_val.setp), sp, hys, i_prev);
      TY_SET_LO:    o_on = below(W'(i_val.setp), sp, hys, i_prev);
      TY_AUTOTUNE:  o_on = i_st.autotune;
      TY_HAND:      o_on = i_st.hand;
      TY_EXT_SP:    o_on = i_st.external_sp;
      TY_SLOPE:     o_on = i_st.slope;
      TY_HALTED:    o_on = i_st.halted;
      TY_ANY_OVER:  o_on = i_st.meas_over | i_st.ext_over;
      TY_MEAS_OVER: o_on = i_st.meas_over;
      TY_EXT_OVER:  o_on = i_st.ext_over;
      TY_LOGIC:     o_on = i_logic;
      TY_DIRECT:    o_on = i_direct;
      TY_POS_HI:    o_on = above(W'(i_val.pos), sp, hys, i_prev);
      TY_POS_LO:    o_on = below(W'(i_val.pos), sp, hys, i_prev);
      TY_POT_FAULT: o_on = i_st.pot_fault;
      default:      o_on = 1'b0;
    endcase
  end
endmodule

// ---- design/zone_pid_event_assign.sv ----
// Purpose: parameter set selection, tuning point and event assignment
// Assumes: panel writes arrive as single-cycle strobes on this clock
// Notes:   PID arithmetic, output polarity, delay and inhibit live elsewhere
// Operation
// - equal thresholds: lowest set index wins
// - hold set while reference inside band
// - zone selection off: set follows setpoint index
// - zone source is setpoint or measured value
// - one band, 0 to 10000, default 20
// - threshold per set, clamped, default 0
// - autotune runs at offset from setpoint
// - type change reinitialises setpoint and hysteresis
// - types 2-5: deviation high, low, out, in
// - types 6-9: absolute measured and setpoint limits
// - types 10-14: state flags
// - types 15-17: over-range on inputs
// - logic gates EV1-3/DO1-3, timers DO4-5
// - direct output only on DO6-9
// - position types need feedback resistor fitted
// - report outputs, hide uninstalled DO6-9
// - resistor removed: position types become none
module zone_pid_event_assign
  import zone_event_pkg::*;
#(
  parameter int                      SETS     = N_SETS,
  parameter logic signed [VAL_W-1:0] MEAS_LO  = 16'shF830, // -2000
  parameter logic signed [VAL_W-1:0] MEAS_HI  = 16'sh61A8, // 25000
  parameter logic signed [VAL_W-1:0] SET_LO   = 16'shF830,
  parameter logic signed [VAL_W-1:0] SET_HI   = 16'sh61A8
) (
  input  wire logic                        i_clk,        // 250 MHz
  input  wire logic                        i_rstn,       // async, low
  input  wire logic                        i_ce,         // clock enable
  input  wire zone_event_pkg::proc_vals_t  i_vals,       // process values
  input  wire zone_event_pkg::status_t     i_status,     // state flags
  input  wire logic [$clog2(SETS)-1:0]     i_sp_index,   // setpoint no.
  input  wire logic                        i_wr,         // write strobe
  input  wire zone_event_pkg::wr_sel_t     i_wr_sel,     // item written
  input  wire logic [3:0]                  i_wr_idx,     // channel or set
  input  wire logic signed [VAL_W-1:0]     i_wr_data,    // value
  input  wire logic [N_CH-1:0][1:0]        i_logic_src,  // gate inputs
  input  wire logic [N_CH-1:0]             i_direct,     // link levels
  input  wire logic                        i_pot_pin,    // resistor fitted
  input  wire logic                        i_opt_pin,    // DO6-9 fitted
  output logic [$clog2(SETS)-1:0]          o_active_set, // active set
  output logic signed [VAL_W-1:0]          o_at_point,   // tuning point
  output logic [N_CH-1:0]                  o_event_on,   // channel states
  output logic [N_DO-1:0]                  o_do_monitor, // DO on states
  output logic [N_CH-1:0][4:0]             o_ch_type,    // assigned types
  output logic                             o_wr_refused  // write refused
);
  localparam int IW = $clog2(SETS);

  initial begin
    if (SETS < 2 || SETS > 16)
      $error("SETS must lie between 2 and 16");
    if (MEAS_LO >= MEAS_HI || SET_LO >= SET_HI)
      $error("range limits out of order");
  end

  // ---- pin synchronisers
  logic [1:0] pot_s_q, opt_s_q;
  logic       pot_fitted, opt_fitted;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pot_s_q <= '0;
      opt_s_q <= '0;
    end else if (i_ce) begin
      pot_s_q <= {pot_s_q[0], i_pot_pin};
      opt_s_q <= {opt_s_q[0], i_opt_pin};
    end
  end
  assign pot_fitted = pot_s_q[1];
  assign opt_fitted = opt_s_q[1];

  // ---- helper functions
  function automatic logic signed [VAL_W-1:0] clamp(
      logic signed [VAL_W-1:0] v, lo, hi);
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction

  function automatic logic is_pos_type(ev_type_t t);
    return t == TY_POS_HI || t == TY_POS_LO || t == TY_POT_FAULT;
  endfunction

  // initial event setpoint for a freshly assigned type
  function automatic logic signed [VAL_W-1:0] init_sp(ev_type_t t);
    case (t)
      TY_DEVIATION_HIGH_ALARM, TY_DEVIATION_OUTSIDE_BAND, TY_DEVIATION_INSIDE_BAND: return DEV_MAX;
      TY_DEV_LO:  return DEV_MIN;
      TY_MEAS_HI: return MEAS_HI;
      TY_MEAS_LO: return MEAS_LO;
      TY_SET_HI:  return SET_HI;
      TY_SET_LO:  return SET_LO;
      TY_POS_HI:  return POS_HI_INIT;
      TY_POS_LO:  return POS_LO_INIT;
      default:    return '0;
    endcase
  endfunction

  function automatic logic signed [VAL_W-1:0] init_hys(ev_type_t t);
    return (t == TY_POS_HI || t == TY_POS_LO) ? POS_HYS_INIT : HYS_INIT;
  endfunction

  // channel 0 is EV1, channel 3 DO1, channel 8 DO6
  function automatic logic type_allowed(int ch, ev_type_t t, logic pot);
    case (t)
      TY_LOGIC:   return ch < CH_DO6;
      TY_DIRECT:  return ch >= CH_DO6;
      TY_POS_HI, TY_POS_LO, TY_POT_FAULT: return pot;
      TY_NONE, TY_DEVIATION_HIGH_ALARM, TY_DEV_LO, TY_DEVIATION_OUTSIDE_BAND, TY_DEVIATION_INSIDE_BAND,
      TY_MEAS_HI, TY_MEAS_LO, TY_SET_HI, TY_SET_LO, TY_AUTOTUNE,
      TY_HAND, TY_EXT_SP, TY_SLOPE, TY_HALTED, TY_ANY_OVER,
      TY_MEAS_OVER, TY_EXT_OVER: return 1'b1;
      default:    return 1'b0;
    endcase
  endfunction

  // ---- write decode
  wire       wr_type   = i_wr && i_wr_sel == WR_TYPE;
  wire       wr_sp     = i_wr && i_wr_sel == WR_EV_SP;
  wire       wr_hys    = i_wr && i_wr_sel == WR_EV_HYS;
  wire       wr_logic  = i_wr && i_wr_sel == WR_LOGIC;
  wire       wr_thr    = i_wr && i_wr_sel == WR_ZONE_THR;
  wire       wr_band   = i_wr && i_wr_sel == WR_BAND;
  wire       wr_mode   = i_wr && i_wr_sel == WR_ZONE_MODE;
  wire       wr_at     = i_wr && i_wr_sel == WR_AT_OFS;
  wire       ch_ok     = int'(i_wr_idx) < N_CH;
  wire       set_ok    = int'(i_wr_idx) < SETS;
  ev_type_t  new_type;
  assign new_type = ev_type_t'(i_wr_data[4:0]);

  // ---- zone parameters
  zone_mode_t                  mode_q;
  logic signed [VAL_W-1:0]     band_q;
  logic [SETS-1:0][VAL_W-1:0]  thr_q;
  logic signed [VAL_W-1:0]     at_ofs_q;
  logic signed [VAL_W-1:0]     zone_ref;
  wire                         mode_ok = i_wr_data[1:0] != 2'h3;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_q   <= ZONE_OFF;
      band_q   <= BAND_INIT;
      thr_q    <= {SETS{ZONE_INIT}};
      at_ofs_q <= AT_OFS_INIT;
    end else if (i_ce) begin
      if (wr_mode && mode_ok)
        mode_q <= zone_mode_t'(i_wr_data[1:0]);
      if (wr_band)
        band_q <= clamp(i_wr_data, '0, BAND_MAX);
      if (wr_thr && set_ok)
        thr_q[i_wr_idx[IW-1:0]] <= clamp(i_wr_data, MEAS_LO, MEAS_HI);
      if (wr_at)
        at_ofs_q <= i_wr_data;
    end
  end

  // selector chooses the value the zones are compared with
  assign zone_ref = (mode_q == ZONE_BY_MEAS) ? i_vals.meas
                                             : i_vals.setp;

  // zone setup must already be valid when enabled
  zone_set_select #(
    .SETS (SETS)
  ) u_zone (
    .i_clk    (i_clk),
    .i_rstn   (i_rstn),
    .i_ce     (i_ce),
    .i_mode   (mode_q),
    .i_ref    (zone_ref),
    .i_band   (band_q),
    .i_thr    (thr_q),
    .i_sp_idx (i_sp_index),
    .o_set    (o_active_set)
  );

  // ---- auto-tuning point
  logic signed [VAL_W-1:0] at_point_q;
  logic signed [VAL_W:0]   at_sum;
  logic signed [VAL_W-1:0] at_sat;

  // offset keeps the limit cycle away from the setpoint itself
  assign at_sum = (VAL_W+1)'(i_vals.setp) + (VAL_W+1)'(at_ofs_q);
  // limit in the wide sum, a narrowed sum would wrap past full scale
  assign at_sat = (at_sum > (VAL_W+1)'(SET_HI)) ? SET_HI
                : (at_sum < (VAL_W+1)'(SET_LO)) ? SET_LO
                : VAL_W'(at_sum);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      at_point_q <= '0;
    else if (i_ce)
      at_point_q <= at_sat;
  end
  assign o_at_point = at_point_q;

  // ---- channel configuration
  chan_cfg_t [N_CH-1:0] cfg_q;
  logic                 refused_q;
  logic [N_CH-1:0]      on_q;
  logic [N_CH-1:0]      on_d;
  logic [N_CH-1:0]      logic_res;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int c = 0; c < N_CH; c++) begin
        cfg_q[c].ty  <= (c == 0) ? TY_DEVIATION_HIGH_ALARM
                      : (c == 1) ? TY_DEV_LO : TY_NONE;
        cfg_q[c].sp  <= (c == 0) ? DEV_MAX : (c == 1) ? DEV_MIN : '0;
        cfg_q[c].hys <= HYS_INIT;
        cfg_q[c].op  <= LOG_AND;
      end
      refused_q <= 1'b0;
    end else if (i_ce) begin
      refused_q <= wr_type && !(ch_ok &&
                   type_allowed(int'(i_wr_idx), new_type, pot_fitted));
      for (int c = 0; c < N_CH; c++) begin
        // resistor option gone: position types drop to none
        if (!pot_fitted && is_pos_type(cfg_q[c].ty)) begin
          cfg_q[c].ty  <= TY_NONE;
          cfg_q[c].sp  <= init_sp(TY_NONE);
          cfg_q[c].hys <= init_hys(TY_NONE);
        end else if (int'(i_wr_idx) == c) begin
          if (wr_type && new_type != cfg_q[c].ty &&
              type_allowed(c, new_type, pot_fitted)) begin
            cfg_q[c].ty  <= new_type;
            cfg_q[c].sp  <= init_sp(new_type);
            cfg_q[c].hys <= init_hys(new_type);
          end
          if (wr_sp)
            cfg_q[c].sp <= i_wr_data;
          if (wr_hys)
            cfg_q[c].hys <= (cfg_q[c].ty == TY_POS_HI ||
                             cfg_q[c].ty == TY_POS_LO)
                            ? clamp(i_wr_data, HYS_MIN, POS_HYS_MAX)
                            : clamp(i_wr_data, HYS_MIN, HYS_MAX);
          if (wr_logic && i_wr_data[1:0] != 2'h3)
            cfg_q[c].op <= logic_op_t'(i_wr_data[1:0]);
        end
      end
    end
  end
  assign o_wr_refused = refused_q;

  // ---- logic combining and channel evaluation
  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_ch
      if (g >= CH_DO4 && g < CH_DO6) begin : g_tmr
        // timer or counter result arrives ready made
        assign logic_res[g] = i_logic_src[g][0];
      end else begin : g_gate
        assign logic_res[g] =
            (cfg_q[g].op == LOG_OR)  ? |i_logic_src[g]
          : (cfg_q[g].op == LOG_XOR) ? ^i_logic_src[g]
          :                            &i_logic_src[g];
      end

      event_level u_lvl (
        .i_cfg    (cfg_q[g]),
        .i_val    (i_vals),
        .i_st     (i_status),
        .i_logic  (logic_res[g]),
        .i_direct (i_direct[g]),
        .i_prev   (on_q[g]),
        .o_on     (on_d[g])
      );
      assign o_ch_type[g] = cfg_q[g].ty;
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      on_q <= '0;
    else if (i_ce)
      on_q <= on_d;
  end
  assign o_event_on = on_q;

  // ---- output monitor
  logic [N_DO-1:0] mon_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      mon_q <= '0;
    else if (i_ce)
      mon_q <= {on_d[N_CH-1:CH_DO6] & {(N_CH-CH_DO6){opt_fitted}},
                on_d[CH_DO6-1:CH_DO1]};
  end
  assign o_do_monitor = mon_q;
endmodule

// ---- test/zone_pid_event_assign_checker.sv ----
// Purpose: port-level properties of the event assignment and tuning point
// Assumes: straps settle through two enabled edges, writes are one-cycle
// Notes:   strap waits use five enabled cycles to cover sync plus register
module zone_pid_event_assign_checker
  import zone_event_pkg::*;
#(
  parameter int                      SETS   = N_SETS,
  parameter logic signed [VAL_W-1:0] SET_LO = 16'shF830,
  parameter logic signed [VAL_W-1:0] SET_HI = 16'sh61A8
) (
  input wire logic                       i_clk,
  input wire logic                       i_rstn,
  input wire logic                       i_ce,
  input wire zone_event_pkg::wr_sel_t    i_wr_sel,
  input wire logic                       i_wr,
  input wire logic [3:0]                 i_wr_idx,
  input wire logic signed [VAL_W-1:0]    i_wr_data,
  input wire logic                       i_pot_pin,
  input wire logic                       i_opt_pin,
  input wire logic signed [VAL_W-1:0]    o_at_point,
  input wire logic [N_CH-1:0]            o_event_on,
  input wire logic [N_DO-1:0]            o_do_monitor,
  input wire logic [N_CH-1:0][4:0]       o_ch_type,
  input wire logic                       o_wr_refused
);
  wire tw = i_wr && i_ce && i_wr_sel == WR_TYPE;
  logic pos_any;
  always_comb begin
    pos_any = 1'b0;
    for (int c = 0; c < N_CH; c++) begin
      if (o_ch_type[c] >= 5'h14) pos_any = 1'b1;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_do_low_mirror: assert property (o_do_monitor[4:0] == o_event_on[7:3])
    else $error("low outputs differ from channel states");
  a_do_opt_hidden: assert property ((!i_opt_pin && i_ce)[*5] |-> o_do_monitor[8:5] == 4'h0)
    else $error("uninstalled outputs shown");
  a_direct_refused: assert property (tw && i_wr_idx < 4'h8 && i_wr_data == 16'sh0013 |=> o_wr_refused)
    else $error("direct type accepted on low channel");
  a_gate_refused: assert property (tw && i_wr_idx inside {[8:11]} && i_wr_data == 16'sh0012 |=> o_wr_refused)
    else $error("gate type accepted on high channel");
  a_pos_refused: assert property ((!i_pot_pin && i_ce)[*5] ##0 (tw && i_wr_idx < 4'hC && i_wr_data inside {[20:22]}) |=> o_wr_refused)
    else $error("position type accepted without resistor");
  a_type_taken: assert property (tw && i_wr_idx < 4'hC && i_wr_data inside {[2:17]} |=> !o_wr_refused && o_ch_type[$past(i_wr_idx)] == $past(i_wr_data[4:0]))
    else $error("legal type write not taken");
  a_quiet_refuse: assert property (!tw |=> !o_wr_refused)
    else $error("refusal without type write");
  a_tune_range: assert property (o_at_point >= SET_LO && o_at_point <= SET_HI)
    else $error("tuning point out of range");
  a_pos_forced: assert property ((!i_pot_pin && i_ce)[*5] |-> !pos_any)
    else $error("position type kept without resistor");
endmodule
bind zone_pid_event_assign zone_pid_event_assign_checker #(.SETS(SETS),
  .SET_LO(SET_LO), .SET_HI(SET_HI)) checker_inst (.i_clk(i_clk),
  .i_rstn(i_rstn), .i_ce(i_ce), .i_wr_sel(i_wr_sel), .i_wr(i_wr),
  .i_wr_idx(i_wr_idx), .i_wr_data(i_wr_data), .i_pot_pin(i_pot_pin),
  .i_opt_pin(i_opt_pin), .o_at_point(o_at_point), .o_event_on(o_event_on),
  .o_do_monitor(o_do_monitor), .o_ch_type(o_ch_type),
  .o_wr_refused(o_wr_refused));

// ---- test/testbench.sv ----
// Purpose: self-checking bench for set selection and event assignment
// Assumes: default parameters, thresholds written as 100 per set
// Notes:   zone model keeps the held set itself, never reads the design
module testbench
  import zone_event_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 0, i_rstn = 0, i_ce = 1, i_wr = 0, i_pot_pin = 0;
  logic i_opt_pin = 0, o_wr_refused, rf;
  proc_vals_t i_vals = '0;
  status_t i_status = '0;
  logic [2:0] i_sp_index = 0, o_active_set;
  wr_sel_t i_wr_sel = WR_TYPE;
  logic [3:0] i_wr_idx = 0;
  logic signed [15:0] i_wr_data = 0, o_at_point;
  logic [N_CH-1:0][1:0] i_logic_src = '0;
  logic [N_CH-1:0] i_direct = '0, o_event_on;
  logic [N_DO-1:0] o_do_monitor;
  logic [N_CH-1:0][4:0] o_ch_type;
  int mismatches = 0, n_compared = 0, r, held, s;
  zone_pid_event_assign zone_pid_event_assign_inst (.i_clk(i_clk),
    .i_rstn(i_rstn), .i_ce(i_ce), .i_vals(i_vals), .i_status(i_status),
    .i_sp_index(i_sp_index), .i_wr(i_wr), .i_wr_sel(i_wr_sel),
    .i_wr_idx(i_wr_idx), .i_wr_data(i_wr_data), .i_logic_src(i_logic_src),
    .i_direct(i_direct), .i_pot_pin(i_pot_pin), .i_opt_pin(i_opt_pin),
    .o_active_set(o_active_set), .o_at_point(o_at_point),
    .o_event_on(o_event_on), .o_do_monitor(o_do_monitor),
    .o_ch_type(o_ch_type), .o_wr_refused(o_wr_refused));
  initial forever #2 i_clk = ~i_clk;
  task automatic chk(logic [15:0] seen, logic [15:0] exp, string m);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(wr_sel_t sel, int idx, int d);
    @(posedge i_clk);
    i_wr <= 1;
    i_wr_sel <= sel;
    i_wr_idx <= 4'(idx);
    i_wr_data <= 16'(d);
    @(posedge i_clk);
    i_wr <= 0;
    #1 rf = o_wr_refused;
  endtask
  task automatic setv(int m, int sp);
    @(posedge i_clk);
    i_vals.meas <= 16'(m);
    i_vals.setp <= 16'(sp);
    step(2);
  endtask
  // lowest set whose upper bound holds the reference
  function automatic int cand(int v);
    for (int i = 0; i < 8; i++) if (v <= 100 * i) return i;
    return 7;
  endfunction
  function automatic bit inband(int v);
    for (int i = 0; i < 8; i++) if (v - 100 * i <= 20 && 100 * i - v <= 20) return 1;
    return 0;
  endfunction
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400us;
    mismatches++;
    wrap_up();
  end
  initial begin
    void'($urandom(72314));
    repeat (12) @(posedge i_clk);
    i_rstn <= 1;
    step(1);
    chk(o_ch_type[0], 2, "ch0 type");
    chk(o_ch_type[1], 3, "ch1 type");
    for (int k = 0; k < 8; k++) begin
      @(posedge i_clk);
      i_sp_index <= 3'($urandom);
      step(2);
      chk(o_active_set, i_sp_index, "set by index");
    end
    $display("index selection done");
    for (int i = 1; i < 8; i++) wr(WR_ZONE_THR, i, 100 * i);
    wr(WR_BAND, 0, 20);
    wr(WR_ZONE_MODE, 0, 1);
    setv(0, 250);
    chk(o_active_set, 3, "zone pick");
    setv(0, 290);
    chk(o_active_set, 3, "held in band");
    setv(0, 321);
    chk(o_active_set, 4, "left band");
    held = 4;
    for (int k = 0; k < 24; k++) begin
      r = $urandom_range(800);
      setv(0, r);
      if (!inband(r)) held = cand(r);
      chk(o_active_set, 16'(held), "zone random");
    end
    wr(WR_ZONE_MODE, 0, 2);
    setv(650, 0);
    chk(o_active_set, 7, "measured zone");
    wr(WR_ZONE_THR, 2, 600);
    wr(WR_ZONE_THR, 6, 600);
    setv(550, 0);
    chk(o_active_set, 2, "equal zones");
    $display("zone selection done");
    wr(WR_EV_SP, 0, 10);
    setv(110, 100);
    chk(o_event_on[1:0], 2'h1, "deviation alarms");
    wr(WR_TYPE, 3, 6);
    chk(o_ch_type[3], 6, "type taken");
    setv(25000, 0);
    chk(o_do_monitor[0], 1, "absolute high");
    wr(WR_EV_SP, 3, 100);
    setv(200, 0);
    chk(o_event_on[3], 1, "low setpoint");
    wr(WR_TYPE, 3, 7);
    wr(WR_TYPE, 3, 6);
    step(2);
    chk(o_event_on[3], 0, "setpoint reinit");
    for (int c = 10; c < 18; c++) begin
      @(posedge i_clk);
      i_status <= status_t'($urandom);
      wr(WR_TYPE, 5, c);
      step(2);
      s = i_status;
      chk(o_event_on[5], c < 15 ? s[17-c] : c == 15 ? s[2] | s[1] : s[18-c],
          "flag types");
    end
    wr(WR_TYPE, 2, 18);
    for (int op = 0; op < 3; op++) begin
      wr(WR_LOGIC, 2, op);
      @(posedge i_clk);
      i_logic_src[2] <= 2'($urandom);
      step(2);
      s = i_logic_src[2];
      chk(o_event_on[2], op == 0 ? s[0] & s[1] : op == 1 ? s[0] | s[1]
          : s[0] ^ s[1], "gate");
    end
    wr(WR_TYPE, 8, 18);
    chk(rf, 1, "gate on high channel");
    wr(WR_TYPE, 0, 19);
    chk({rf, o_ch_type[0]}, 6'h22, "direct on low");
    wr(WR_TYPE, 3, 0);
    chk(rf, 1, "bad code");
    wr(WR_TYPE, 8, 19);
    @(posedge i_clk);
    i_direct[8] <= 1;
    step(2);
    chk({o_event_on[8], o_do_monitor[5]}, 2'h2, "option hidden");
    i_opt_pin <= 1;
    step(4);
    chk(o_do_monitor[5], 1, "option shown");
    wr(WR_TYPE, 4, 20);
    chk(rf, 1, "no resistor");
    i_pot_pin <= 1;
    step(4);
    wr(WR_TYPE, 4, 20);
    chk(o_ch_type[4], 20, "resistor fitted");
    i_pot_pin <= 0;
    step(5);
    chk(o_ch_type[4], 1, "forced none");
    $display("event assignment done");
    wr(WR_AT_OFS, 0, 50);
    setv(0, 1000);
    chk(o_at_point, 1050, "tuning offset");
    wr(WR_AT_OFS, 0, 25000);
    step(2);
    chk(o_at_point, 25000, "tuning clamp");
    setv(0, 25000);
    chk(o_at_point, 25000, "tuning no wrap");
    @(posedge i_clk);
    i_ce <= 0;
    wr(WR_TYPE, 3, 8);
    chk(o_ch_type[3], 6, "frozen by enable");
    @(posedge i_clk);
    i_ce <= 1;
    step(1);
    $display("tuning point done");
    wrap_up();
  end
endmodule
